// *** hw/scm_top.sv ***
// System clock select and low-power mode controller with AXI4-Lite registers
//
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
// Contract
// RQ1: Select field codes 0-6 give high-speed clock divided 1..64, code 7 low-speed.
// RQ2: Fast source select routes external crystal or internal RC onto high-speed clock.
// RQ3: Slow source select routes external 32.768 kHz crystal or internal RC.
// RQ4: Fast mode runs CPU from high-speed clock divided by 1 up to 64.
// RQ5: After moving to low-speed, high-speed oscillator follows its own enable bit.
// RQ6: Fast mode keeps CPU, high-speed, low-speed and slow RC clocks running.
// RQ7: Slow mode runs CPU from low-speed clock; high-speed follows its enable.
// RQ8: Stop with both keep-alive bits 0 enters sleep; CPU and low-speed stop.
// RQ9: In sleep the slow RC runs only while the watchdog is enabled.
// RQ10: Stop with fast 0, slow 1 enters idle_slow_only_mode: only low-speed clock runs.
// RQ11: Stop with both keep-alive bits 1 enters idle_both_clocks_mode: both clocks keep running.
// RQ12: Stop with fast 1, slow 0 enters idle_fast_only_mode: only high-speed clock runs.
// RQ13: Fast source select 0 picks internal RC, 1 picks external crystal.
// RQ14: A switch completes after four current system periods plus edge alignment.
// RQ15: Clock source changes never put a short pulse onto the CPU clock.
module scm_top
  import scm_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Oscillator levels
  input wire logic ext_fast_crystal,
  input wire logic int_fast_rc,
  input wire logic ext_slow_crystal,
  input wire logic int_slow_rc,
  // CPU stop instruction and wake-up event
  input wire logic halt_req,
  input wire logic wake_req,
  // AXI4-Lite write
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Clocks and oscillator controls
  output logic cpu_clk_reg,
  output logic high_speed_clock_reg,
  output logic low_speed_clock_reg,
  output logic fast_osc_run_reg,
  output logic slow_osc_run_reg,
  output logic int_slow_rc_run_reg,
  output logic sys_slow_reg,
  output logic [2:0] mode_out_reg
);
  logic [7:0] scc_reg;
  logic [1:0] ctrl_reg;
  logic [4:0] app_reg;
  scm_mode_t mode_reg;
  logic [3:0] awaddr_q;
  logic aw_full;
  logic w_full;
  logic [7:0] wbyte_q;
  logic wstrb_q;
  logic do_wr;
  logic [2:0] tgt_cks;
  logic [2:0] app_cks;
  logic app_fhs;
  logic app_fss;
  logic hs_cur;
  logic hs_tgt;
  logic ls_cur;
  logic ls_tgt;
  logic [DIV_W-1:0] taps_cur;
  logic [DIV_W-1:0] taps_tgt;
  logic [DIV_W-1:0] taps_rc;
  logic [DIV_W-1:0] taps_xt;
  logic cand_cur;
  logic cand_tgt;
  logic sw_out;
  logic sw_adopt;
  logic sw_busy;
  logic sw_req;
  logic fosc_en;
  logic wdt_en;
  logic hs_run;
  logic ls_run;
  logic int_slow_rc_run;
  logic [31:0] rd_mux;
  logic rd_err;

  assign tgt_cks = scc_reg[CKS_LSB+2:CKS_LSB];
  assign app_cks = app_reg[4:2];
  assign app_fhs = app_reg[1];
  assign app_fss = app_reg[0];
  assign fosc_en = ctrl_reg[FOSC_EN_BIT];
  assign wdt_en = ctrl_reg[WDT_EN_BIT];

  // Source routing, 0 picks the internal oscillator
  assign hs_cur = app_fhs ? ext_fast_crystal : int_fast_rc; // see RQ2 see RQ13
  assign hs_tgt = scc_reg[FHS_BIT] ? ext_fast_crystal : int_fast_rc; // see RQ2 see RQ13
  assign ls_cur = app_fss ? ext_slow_crystal : int_slow_rc; // see RQ3
  assign ls_tgt = scc_reg[FSS_BIT] ? ext_slow_crystal : int_slow_rc; // see RQ3

  scm_div u_div_rc (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .src(int_fast_rc),
    .taps(taps_rc)
  );

  scm_div u_div_xt (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .src(ext_fast_crystal),
    .taps(taps_xt)
  );

  // One divider per fixed source, so the taps stay in phase across a source change
  assign taps_cur = app_fhs ? taps_xt : taps_rc; // see RQ15
  assign taps_tgt = scc_reg[FHS_BIT] ? taps_xt : taps_rc;

  // Code 0 is the undivided clock, 1..6 a divider tap, 7 the low-speed clock
  function automatic logic pick(input logic [2:0] cks, input logic hs,
                                input logic [DIV_W-1:0] taps, input logic ls);
    logic r;
    r = hs;
    if (cks == CKS_LOW)
      r = ls;
    else if (cks != CKS_FULL)
      r = taps[cks - 3'h1];
    return r;
  endfunction

  assign cand_cur = pick(app_cks, hs_cur, taps_cur, ls_cur); // see RQ1 see RQ4
  assign cand_tgt = pick(tgt_cks, hs_tgt, taps_tgt, ls_tgt); // see RQ1
  assign sw_req = {tgt_cks, scc_reg[FHS_BIT], scc_reg[FSS_BIT]} != app_reg;

  scm_clksw u_sw (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .cur_src(cand_cur),
    .tgt_src(cand_tgt),
    .req(sw_req),
    .out_reg(sw_out),
    .adopt(sw_adopt),
    .busy(sw_busy)
  );

  // Applied selection moves only when the switch has parked
  always_ff @(posedge clk)
  begin
    if (!nrst)
      app_reg <= SCC_RST[7:3];
    else if (sw_adopt)
      app_reg <= {tgt_cks, scc_reg[FHS_BIT], scc_reg[FSS_BIT]}; // see RQ14
  end

  // Operating mode
  always_ff @(posedge clk)
  begin
    if (!nrst)
      mode_reg <= M_RUN;
    else if (ce)
    begin
      case (mode_reg)
        M_RUN:
        begin
          if (halt_req)
          begin
            case ({scc_reg[FHK_BIT], scc_reg[FSK_BIT]})
              2'b00: mode_reg <= M_SLEEP; // see RQ8
              2'b01: mode_reg <= M_IDLE_SLOW; // see RQ10
              2'b11: mode_reg <= M_IDLE_BOTH; // see RQ11
              default: mode_reg <= M_IDLE_FAST; // see RQ12
            endcase
          end
        end
        M_SLEEP, M_IDLE_SLOW, M_IDLE_BOTH, M_IDLE_FAST:
        begin
          if (wake_req)
            mode_reg <= M_RUN;
        end
        default:
          mode_reg <= M_RUN;
      endcase
    end
  end

  // Clock gating per mode
  always_comb
  begin
    hs_run = 1'b0;
    ls_run = 1'b0;
    int_slow_rc_run = 1'b1;
    case (mode_reg)
      M_RUN:
      begin
        hs_run = (app_cks != CKS_LOW) || fosc_en; // see RQ5 see RQ6 see RQ7
        ls_run = 1'b1; // see RQ6
      end
      M_SLEEP:
        int_slow_rc_run = wdt_en; // see RQ9
      M_IDLE_SLOW:
        ls_run = 1'b1; // see RQ10
      M_IDLE_BOTH:
      begin
        hs_run = 1'b1; // see RQ11
        ls_run = 1'b1;
      end
      M_IDLE_FAST:
        hs_run = 1'b1; // see RQ12
      default:
        hs_run = 1'b0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      cpu_clk_reg <= 1'b0;
      high_speed_clock_reg <= 1'b0;
      low_speed_clock_reg <= 1'b0;
      fast_osc_run_reg <= 1'b1;
      slow_osc_run_reg <= 1'b1;
      int_slow_rc_run_reg <= 1'b1;
      sys_slow_reg <= 1'b0;
      mode_out_reg <= 3'h0;
    end
    else if (ce)
    begin
      cpu_clk_reg <= (mode_reg == M_RUN) && sw_out; // see RQ8 see RQ15
      high_speed_clock_reg <= hs_run && hs_cur;
      low_speed_clock_reg <= ls_run && ls_cur; // see RQ8
      fast_osc_run_reg <= hs_run;
      slow_osc_run_reg <= ls_run;
      int_slow_rc_run_reg <= int_slow_rc_run;
      sys_slow_reg <= app_cks == CKS_LOW; // see RQ7
      mode_out_reg <= mode_reg;
    end
  end

  // AXI4-Lite write path: address and data taken in either order
  assign do_wr = aw_full && w_full && !s_axi_bvalid;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      aw_full <= 1'b0;
      w_full <= 1'b0;
      awaddr_q <= 4'h0;
      wbyte_q <= 8'h00;
      wstrb_q <= 1'b0;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awaddr_q <= s_axi_awaddr;
        aw_full <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wbyte_q <= s_axi_wdata[7:0];
        wstrb_q <= s_axi_wstrb[0];
        w_full <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_wr)
      begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q == ADDR_SCC || awaddr_q == ADDR_CTRL ||
                        awaddr_q == ADDR_STAT) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      scc_reg <= SCC_RST;
      ctrl_reg <= CTRL_RST;
    end
    else if (ce && do_wr && wstrb_q)
    begin
      if (awaddr_q == ADDR_SCC)
        scc_reg <= wbyte_q & SCC_WMASK;
      if (awaddr_q == ADDR_CTRL)
        ctrl_reg <= wbyte_q[1:0];
    end
  end

  // AXI4-Lite read path
  always_comb
  begin
    rd_mux = 32'h0;
    rd_err = 1'b0;
    case (s_axi_araddr)
      ADDR_SCC: rd_mux = {24'h0, scc_reg};
      ADDR_CTRL: rd_mux = {30'h0, ctrl_reg};
      ADDR_STAT: rd_mux = {23'h0, app_reg, sw_busy, mode_reg};
      default: rd_err = 1'b1;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  default clocking dc @(posedge clk); endclocking
  default disable iff (!nrst);

  a_low_code_slow: assert property (ce |=> sys_slow_reg == ($past(app_cks) == CKS_LOW)) // see RQ1
    else $error("slow flag does not match select code");
  a_fast_rc_route: assert property ((ce && hs_run && !app_fhs) |=> // see RQ13
    high_speed_clock_reg == $past(int_fast_rc))
    else $error("high-speed clock not from internal RC");
  a_slow_xtal_route: assert property ((ce && ls_run && app_fss) |=> // see RQ3
    low_speed_clock_reg == $past(ext_slow_crystal))
    else $error("low-speed clock not from external crystal");
  a_fast_all_on: assert property ((ce && mode_reg == M_RUN && app_cks != CKS_LOW) |=> // see RQ6
    fast_osc_run_reg && slow_osc_run_reg && int_slow_rc_run_reg)
    else $error("clock off in fast mode");
  a_slow_fast_enable: assert property ((ce && mode_reg == M_RUN && app_cks == CKS_LOW) |=> // see RQ5
    fast_osc_run_reg == $past(fosc_en))
    else $error("high-speed run ignores its enable in slow mode");
  a_sleep_entry: assert property ((ce && mode_reg == M_RUN && halt_req && // see RQ8
    scc_reg[1:0] == 2'b00) |=> mode_reg == M_SLEEP ##1 (!ce || mode_out_reg == M_SLEEP && !cpu_clk_reg && !slow_osc_run_reg))
    else $error("sleep not entered or clocks running");
  a_sleep_wdt_rc: assert property ((ce && mode_reg == M_SLEEP) |=> // see RQ9
    int_slow_rc_run_reg == $past(wdt_en))
    else $error("slow RC ignores watchdog in sleep");
  a_idle_slow_only_mode_clocks: assert property ((ce && mode_reg == M_IDLE_SLOW) |=> // see RQ10
    slow_osc_run_reg && !fast_osc_run_reg && !cpu_clk_reg)
    else $error("idle_slow_only_mode clock state wrong");
  a_idle_both_clocks_mode_clocks: assert property ((ce && mode_reg == M_RUN && halt_req && // see RQ11
    scc_reg[1:0] == 2'b11) |=> ##1 (!ce || fast_osc_run_reg && slow_osc_run_reg))
    else $error("idle_both_clocks_mode clock state wrong");
  a_idle_fast_only_mode_clocks: assert property ((ce && mode_reg == M_IDLE_FAST) |=> // see RQ12
    fast_osc_run_reg && !slow_osc_run_reg && !low_speed_clock_reg)
    else $error("idle_fast_only_mode clock state wrong");
  a_app_holds_busy: assert property ((sw_req && !sw_adopt) |=> app_reg == $past(app_reg)) // see RQ14
    else $error("selection applied without switch sequence");

  c_sleep_seen: cover property (mode_reg == M_RUN ##1 mode_reg == M_SLEEP);
  c_idle_both: cover property (mode_reg == M_IDLE_BOTH);
  c_to_slow: cover property (sw_adopt && tgt_cks == CKS_LOW);
  c_wr_done: cover property (s_axi_bvalid && s_axi_bready);
endmodule // scm_top

// *** hw/scm_pkg.sv ***
// Package: constants and types for the system clock and mode controller
package scm_pkg;
  // Register byte addresses
  localparam logic [3:0] ADDR_SCC = 4'h0;
  localparam logic [3:0] ADDR_CTRL = 4'h4;
  localparam logic [3:0] ADDR_STAT = 4'h8;
  // system_clock_control_reg fields
  localparam int CKS_LSB = 5;
  localparam int FHS_BIT = 3;
  localparam int FSS_BIT = 2;
  localparam int FHK_BIT = 1;
  localparam int FSK_BIT = 0;
  localparam logic [7:0] SCC_RST = 8'h00;
  localparam logic [7:0] SCC_WMASK = 8'hef;
  // Control register fields
  localparam int FOSC_EN_BIT = 0;
  localparam int WDT_EN_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h1;
  // Select codes
  localparam logic [2:0] CKS_FULL = 3'h0;
  localparam logic [2:0] CKS_LOW = 3'h7;
  // Switch delay in current system clock periods
  localparam logic [2:0] SW_CUR_PERIODS = 3'h4;
  localparam int DIV_W = 6;
  localparam logic [DIV_W-1:0] DIV_RST = 6'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    M_RUN,
    M_SLEEP,
    M_IDLE_SLOW,
    M_IDLE_BOTH,
    M_IDLE_FAST
  } scm_mode_t;
  typedef enum logic [1:0] {
    SW_FOLLOW,
    SW_COUNT,
    SW_PARK
  } scm_sw_t;
endpackage

// *** hw/scm_div.sv ***
// Ripple-free divider: counts rising edges of a sampled clock level
`timescale 1ns/1ps
module scm_div
  import scm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Source level and divided taps, tap k is source/2^(k+1)
  input wire logic src,
  output logic [DIV_W-1:0] taps
);
  logic src_q;
  logic [DIV_W-1:0] cnt_reg;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      src_q <= 1'b0;
      cnt_reg <= DIV_RST;
    end
    else if (ce)
    begin
      src_q <= src;
      if (src && !src_q)
        cnt_reg <= cnt_reg + 6'h01;
    end
  end

  assign taps = cnt_reg;
endmodule // scm_div

// *** hw/scm_clksw.sv ***
// Glitch-free switch between the current and target clock levels
`timescale 1ns/1ps
module scm_clksw
  import scm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Sources and request
  input wire logic cur_src,
  input wire logic tgt_src,
  input wire logic req,
  // Results
  output logic out_reg,
  output logic adopt,
  output logic busy
);
  scm_sw_t st_reg;
  logic [2:0] cnt_reg;
  logic fall;

  assign fall = out_reg && !cur_src;
  assign adopt = ce && st_reg == SW_PARK && !tgt_src;
  assign busy = st_reg != SW_FOLLOW;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      st_reg <= SW_FOLLOW;
      cnt_reg <= 3'h0;
      out_reg <= 1'b0;
    end
    else if (ce)
    begin
      case (st_reg)
        SW_FOLLOW:
        begin
          out_reg <= cur_src;
          cnt_reg <= 3'h0;
          if (req)
            st_reg <= SW_COUNT;
        end
        SW_COUNT:
        begin
          // Wait out whole periods of the clock being left
          out_reg <= cur_src; // see RQ14
          if (fall)
          begin
            cnt_reg <= cnt_reg + 3'h1;
            if (cnt_reg + 3'h1 == SW_CUR_PERIODS)
              st_reg <= SW_PARK;
          end
        end
        SW_PARK:
        begin
          // Held low until the target is low too, so no short pulse
          out_reg <= 1'b0; // see RQ15
          if (!tgt_src)
            st_reg <= SW_FOLLOW; // see RQ14
        end
        default:
          st_reg <= SW_FOLLOW;
      endcase
    end
  end

  a_adopt_after_four: assert property (@(posedge clk) disable iff (!nrst) // see RQ14
    adopt |-> cnt_reg == SW_CUR_PERIODS && !out_reg)
    else $error("switch adopted before four current periods");
  a_park_output_low: assert property (@(posedge clk) disable iff (!nrst) // see RQ15
    (ce && st_reg == SW_COUNT && fall && cnt_reg == 3'h3) |=> st_reg == SW_PARK && !out_reg)
    else $error("output not parked low after fourth fall");
  c_switch_done: cover property (@(posedge clk) disable iff (!nrst) adopt);
endmodule // scm_clksw

// *** tb/tb_top.sv ***
// Self-checking testbench for the system clock and mode controller
`timescale 1ns/1ps
module tb_top
  import scm_pkg::*;
;
  logic clk, nrst, ce, ext_fast_crystal, int_fast_rc, ext_slow_crystal, int_slow_rc;
  logic halt_req, wake_req;
  logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic cpu_clk_reg, high_speed_clock_reg, low_speed_clock_reg, fast_osc_run_reg;
  logic slow_osc_run_reg, int_slow_rc_run_reg, sys_slow_reg, gl_last;
  logic [2:0] mode_out_reg;
  logic [7:0] cyc;
  int num_errors, tests_run, e_cpu, e_hs, e_ls, gl_n, gl_len;
  localparam int W = 2048;

  scm_top i_scm_top (.clk, .nrst, .ce, .ext_fast_crystal, .int_fast_rc, .ext_slow_crystal,
    .int_slow_rc, .halt_req, .wake_req, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu_clk_reg, .high_speed_clock_reg,
    .low_speed_clock_reg, .fast_osc_run_reg, .slow_osc_run_reg, .int_slow_rc_run_reg,
    .sys_slow_reg, .mode_out_reg);

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Oscillator periods in clk cycles: fast RC 4, fast crystal 8, slow crystal 32, slow RC 64
  always @(posedge clk)
  begin
    cyc <= cyc + 8'h01;
    int_fast_rc <= cyc[1];
    ext_fast_crystal <= cyc[2];
    ext_slow_crystal <= cyc[4];
    int_slow_rc <= cyc[5];
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t %s: got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic near(input int got, input int exp, input int tol, input string m);
    chk({31'h0, got >= exp - tol && got <= exp + tol}, 32'h1, m);
  endtask

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    int k;
    k = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk);
      k++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && k < 200);
    chk({31'h0, s_axi_bvalid}, 32'h1, "bvalid seen");
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er}, "bresp");
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    k = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk);
      k++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && k < 200);
    chk({31'h0, s_axi_rvalid}, 32'h1, "rvalid seen");
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er,
                        input string m);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk(d, ed, m);
    chk({30'h0, r}, {30'h0, er}, "rresp");
  endtask

  // Writes the selection and waits until the applied selection reports it
  task automatic set_scc(input logic [7:0] v);
    logic [31:0] d;
    logic [1:0] r;
    int k;
    axi_wr(ADDR_SCC, {24'h0, v}, RESP_OKAY);
    k = 0;
    do
    begin
      axi_rd(ADDR_STAT, d, r);
      k++;
    end while ((d[8:4] !== {v[7:5], v[3:2]} || d[3] !== 1'b0) && k < 1000);
    chk({27'h0, d[8:4]}, {27'h0, v[7:5], v[3:2]}, "switch done");
  endtask

  task automatic cnt_edges(input int n);
    logic pc, ph, pl;
    e_cpu = 0;
    e_hs = 0;
    e_ls = 0;
    @(posedge clk);
    pc = cpu_clk_reg;
    ph = high_speed_clock_reg;
    pl = low_speed_clock_reg;
    repeat (n)
    begin
      @(posedge clk);
      if (cpu_clk_reg && !pc) e_cpu++;
      if (high_speed_clock_reg && !ph) e_hs++;
      if (low_speed_clock_reg && !pl) e_ls++;
      pc = cpu_clk_reg;
      ph = high_speed_clock_reg;
      pl = low_speed_clock_reg;
    end
  endtask

  task automatic pulse(input logic h);
    @(posedge clk);
    if (h)
      halt_req <= 1'b1;
    else
      wake_req <= 1'b1;
    @(posedge clk);
    halt_req <= 1'b0;
    wake_req <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic t_reset();
    rd_chk(ADDR_SCC, {24'h0, SCC_RST}, RESP_OKAY, "scc reset");
    rd_chk(ADDR_CTRL, {30'h0, CTRL_RST}, RESP_OKAY, "ctrl reset");
    chk({29'h0, mode_out_reg}, 32'h0, "mode reset");
    chk({29'h0, fast_osc_run_reg, slow_osc_run_reg, int_slow_rc_run_reg}, 32'h7, "runs");
    axi_wr(ADDR_SCC, 32'h0000_00ff, RESP_OKAY);
    rd_chk(ADDR_SCC, 32'h0000_00ef, RESP_OKAY, "scc unused bit");
    axi_wr(4'hc, 32'h0000_00ff, RESP_SLVERR);
    rd_chk(4'hc, 32'h0, RESP_SLVERR, "unmapped");
  endtask

  task automatic t_fast();
    for (int c = 0; c < 7; c++)
    begin
      set_scc({c[2:0], 5'h00});
      cnt_edges(W);
      near(e_cpu, W / (4 << c), 1, "cpu divided");
      near(e_hs, W / 4, 1, "hs rc");
      near(e_ls, W / 64, 1, "ls in fast");
    end
    set_scc(8'h28);
    cnt_edges(W);
    near(e_cpu, W / 16, 1, "cpu xtal");
    near(e_hs, W / 8, 1, "hs xtal");
  endtask

  task automatic t_slow();
    int k;
    set_scc(8'h04);
    axi_wr(ADDR_SCC, 32'h0000_00e4, RESP_OKAY);
    k = 0;
    while (sys_slow_reg !== 1'b1 && k < 200)
    begin
      @(posedge clk);
      k++;
    end
    near(k, 29, 16, "switch delay");
    cnt_edges(W);
    near(e_cpu, W / 32, 1, "cpu slow xtal");
    near(e_hs, W / 4, 1, "hs kept");
    set_scc(8'he0);
    axi_wr(ADDR_CTRL, 32'h0, RESP_OKAY);
    cnt_edges(W);
    near(e_cpu, W / 64, 1, "cpu slow rc");
    near(e_hs, 0, 1, "hs stopped");
    chk({30'h0, sys_slow_reg, fast_osc_run_reg}, 32'h2, "slow flags");
    axi_wr(ADDR_CTRL, {30'h0, CTRL_RST}, RESP_OKAY);
  endtask

  task automatic t_halt();
    logic [2:0] md [5] = '{M_SLEEP, M_IDLE_SLOW, M_IDLE_FAST, M_IDLE_BOTH, M_SLEEP};
    for (int k = 0; k < 5; k++)
    begin
      axi_wr(ADDR_CTRL, {30'h0, k == 4, 1'b1}, RESP_OKAY);
      set_scc({6'h01, k[1:0]});
      pulse(1'b1);
      chk({29'h0, mode_out_reg}, {29'h0, md[k]}, "halt mode");
      cnt_edges(256);
      near(e_cpu, 0, 0, "cpu halted");
      near(e_hs, k[1] ? 64 : 0, 1, "hs halted");
      near(e_ls, k[0] ? 8 : 0, 1, "ls halted");
      if (k[1:0] == 2'h0) chk({31'h0, int_slow_rc_run_reg}, {31'h0, k == 4}, "rc sleep");
      pulse(1'b0);
      chk({29'h0, mode_out_reg}, 32'h0, "woken");
    end
  endtask

  // Pulses of the CPU clock in steady run last at least the fastest half period
  always @(posedge clk)
  begin
    if (!nrst || halt_req || mode_out_reg !== 3'h0)
      gl_n = 0;
    else if (cpu_clk_reg !== gl_last)
    begin
      if (gl_n >= 2) chk({31'h0, gl_len >= 2}, 32'h1, "cpu pulse width");
      gl_n++;
      gl_len = 0;
    end
    gl_len++;
    gl_last = cpu_clk_reg;
  end

  initial
  begin
    #(25 * 100000);
    num_errors++;
    end_sim();
  end

  initial
  begin
    ce = 1'b1;
    nrst = 1'b0;
    cyc = 8'h00;
    int_fast_rc = 1'b0;
    ext_fast_crystal = 1'b0;
    ext_slow_crystal = 1'b0;
    int_slow_rc = 1'b0;
    halt_req = 1'b0;
    wake_req = 1'b0;
    s_axi_awaddr = 4'h0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 4'h0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_fast();
    t_slow();
    t_halt();
    end_sim();
  end
endmodule // tb_top
